//--- rtl/boot_section_address_map.sv
// Purpose: boot section map, section split and pointer decode for self-programming
// Assumes: fuse and variant inputs are static; flash array reports write completion
// Notes: one clock domain; all outputs registered
`timescale 1ns/100ps
// Notes on behaviour
// - on the 8K-word variant fuse 11/10/01/00 puts the boot section at 1F00/1E00/1C00/1800, ending at 1FFF.
// - on the 16K-word variant fuse 11/10/01/00 puts the boot section at 3F00/3E00/3C00/3800, ending at 3FFF.
// - the application section runs from zero to one below boot start; boot is 4, 8, 16 or 32 pages.
// - the stalling section is always the top 32 pages regardless of the fuse.
// - the concurrent read section is 0000-17FF (96 pages) or 0000-37FF (224 pages).
// - the program counter is 13 bits on the 8K-word variant.
// - the program counter is 14 bits on the 16K-word variant.
// - pages hold 64 words, low six counter bits pick the word and upper bits the page.
// - the page number comes from pointer bits 13:7 or 14:7.
// - the buffer word index is pointer bits 6:1, and software keeps it zero for a page write.
// - pointer bit 0 is not a word address bit; it picks the byte on load reads.
// - the counter top bit maps to pointer bit 13 or 14 and the page-word top bit to pointer bit 6.
// - a program operation to the concurrent read section sets busy and blocks access to it.
// - a page write to the stalling section stalls the cpu until the write ends.
module boot_section_address_map
  import boot_map_pkg::*;
(
  input wire logic mclk_i, // cpu clock
  input wire logic rst_i, // async reset, active high
  input wire logic large_variant_i, // 1 selects 16K-word variant, static
  input wire logic boot_size_sel_hi_i, // boot size fuse high bit, static
  input wire logic boot_size_sel_lo_i, // boot size fuse low bit, static
  input wire logic [PTR_W-1:0] pointer_i, // z pointer from cpu
  input wire logic prog_start_i, // pulse: page erase or page write starts
  input wire logic prog_is_write_i, // with prog_start_i: 1 page write, 0 erase
  input wire logic page_load_i, // pulse: temporary buffer word load
  input wire logic section_reenable_i, // pulse: re-enable concurrent section
  input wire logic prog_done_i, // pulse: flash array finished
  input wire logic [ADDR_W-1:0] fetch_addr_i, // word address of cpu read
  output logic [ADDR_W-1:0] boot_start_o, // boot start and reset vector
  output logic [ADDR_W-1:0] app_end_o, // last application word
  output logic [ADDR_W-1:0] stall_start_o, // first stalling section word
  output logic [PAGE_W-1:0] boot_pages_o, // boot size in pages
  output logic [PAGE_W-1:0] conc_pages_o, // concurrent section pages
  output logic [ADDR_W-1:0] counter_top_bit_o, // one-hot mask of counter top bit
  output logic [PAGE_W-1:0] page_select_field_o, // page number from pointer
  output logic [WORD_FIELD_W-1:0] word_select_field_o, // word in page from pointer
  output logic byte_select_o, // pointer bit 0, load byte select
  output logic word_field_nonzero_o, // page write issued with word field not zero
  output logic concurrent_section_busy_o, // concurrent section blocked
  output logic fetch_blocked_o, // cpu read hits blocked section
  output logic cpu_stall_o // cpu halted during stalling write
);
  // map group: variant and fuse copies and the boundaries derived from them
  logic large_reg;
  logic large_next;
  logic [1:0] fuse_reg;
  logic [1:0] fuse_next;
  logic [ADDR_W-1:0] boot_reg;
  logic [ADDR_W-1:0] boot_next;
  logic [ADDR_W-1:0] app_reg;
  logic [ADDR_W-1:0] app_next;
  logic [ADDR_W-1:0] stall_reg;
  logic [ADDR_W-1:0] stall_next;
  logic [ADDR_W-1:0] top_reg;
  logic [ADDR_W-1:0] top_next;
  logic [PAGE_W-1:0] bpages_reg;
  logic [PAGE_W-1:0] bpages_next;
  logic [PAGE_W-1:0] cpages_reg;
  logic [PAGE_W-1:0] cpages_next;
  // pointer group: fields split off the z pointer
  logic [PAGE_W-1:0] page_reg;
  logic [PAGE_W-1:0] page_next;
  logic [WORD_FIELD_W-1:0] word_reg;
  logic [WORD_FIELD_W-1:0] word_next;
  logic byte_reg;
  logic byte_next;
  logic nz_reg;
  logic nz_next;
  // control group: program sequencing, busy and stall
  logic blk_reg;
  logic blk_next;
  logic stall_o_reg;
  logic stall_o_next;
  logic busy_reg;
  logic busy_next;
  prog_state_t state_reg;
  prog_state_t state_next;
  logic [ADDR_W-1:0] tgt_addr;
  logic tgt_in_stall;

  always_comb begin
    large_next = large_variant_i;
    fuse_next = {boot_size_sel_hi_i, boot_size_sel_lo_i};
    case (fuse_reg)
      2'b11: begin
        boot_next = large_reg ? BOOT_11_16K : BOOT_11_8K;
        bpages_next = BOOT_PAGES_11;
      end
      2'b10: begin
        boot_next = large_reg ? BOOT_10_16K : BOOT_10_8K;
        bpages_next = BOOT_PAGES_10;
      end
      2'b01: begin
        boot_next = large_reg ? BOOT_01_16K : BOOT_01_8K;
        bpages_next = BOOT_PAGES_01;
      end
      default: begin
        boot_next = large_reg ? BOOT_00_16K : BOOT_00_8K;
        bpages_next = BOOT_PAGES_00;
      end
    endcase
    app_next = boot_next - 14'h0001;
    stall_next = large_reg ? STALL_START_16K : STALL_START_8K;
    cpages_next = large_reg ? CONC_PAGES_16K : CONC_PAGES_8K;
    top_next = large_reg ? (14'h0001 << CNT_TOP_16K) : (14'h0001 << CNT_TOP_8K);
  end

  // pointer fields follow the pointer every cycle, one edge late
  always_comb begin
    // pointer split; bit 0 skipped so counter bit n sits at pointer bit n+1
    page_next = large_reg ? pointer_i[PTR_CNT_TOP_16K:PAGE_LSB]
                          : {1'b0, pointer_i[PTR_CNT_TOP_8K:PAGE_LSB]};
    word_next = pointer_i[PTR_PAGE_WORD_TOP:WORD_LSB];
    byte_next = pointer_i[0];
    nz_next = prog_start_i && prog_is_write_i && (word_next != '0);
  end

  // a start is taken only while idle; busy clears only while idle
  always_comb begin
    tgt_addr = large_reg ? pointer_i[PTR_CNT_TOP_16K:WORD_LSB]
                         : {1'b0, pointer_i[PTR_CNT_TOP_8K:WORD_LSB]};
    // boundary being loaded: a start on the second edge after reset already sees the variant
    tgt_in_stall = (tgt_addr >= stall_next);
    state_next = state_reg;
    busy_next = busy_reg;
    case (state_reg)
      ST_IDLE: begin
        if (prog_start_i) begin
          if (!tgt_in_stall) begin
            state_next = ST_CONC;
            busy_next = 1'b1;
          end else if (prog_is_write_i) begin
            state_next = ST_STALL;
          end else begin
            state_next = ST_CONC;
          end
        end else if (page_load_i || section_reenable_i) begin
          busy_next = 1'b0;
        end
      end
      ST_CONC: begin
        if (prog_done_i) state_next = ST_IDLE;
      end
      ST_STALL: begin
        if (prog_done_i) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    blk_next = busy_next && (fetch_addr_i < stall_next);
    stall_o_next = (state_next == ST_STALL);
  end

  // map group registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      large_reg <= 1'b0;
      fuse_reg <= 2'b00;
      boot_reg <= '0;
      app_reg <= '0;
      stall_reg <= '0;
      top_reg <= '0;
      bpages_reg <= '0;
      cpages_reg <= '0;
    end else begin
      large_reg <= large_next;
      fuse_reg <= fuse_next;
      boot_reg <= boot_next;
      app_reg <= app_next;
      stall_reg <= stall_next;
      top_reg <= top_next;
      bpages_reg <= bpages_next;
      cpages_reg <= cpages_next;
    end
  end

  // pointer group registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      page_reg <= '0;
      word_reg <= '0;
      byte_reg <= 1'b0;
      nz_reg <= 1'b0;
    end else begin
      page_reg <= page_next;
      word_reg <= word_next;
      byte_reg <= byte_next;
      nz_reg <= nz_next;
    end
  end

  // control group registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_reg <= 1'b0;
      stall_o_reg <= 1'b0;
      busy_reg <= 1'b0;
      state_reg <= ST_IDLE;
    end else begin
      blk_reg <= blk_next;
      stall_o_reg <= stall_o_next;
      busy_reg <= busy_next;
      state_reg <= state_next;
    end
  end

  // every output comes straight from its register
  assign boot_start_o = boot_reg;
  assign app_end_o = app_reg;
  assign stall_start_o = stall_reg;
  assign boot_pages_o = bpages_reg;
  assign conc_pages_o = cpages_reg;
  assign counter_top_bit_o = top_reg;
  assign page_select_field_o = page_reg;
  assign word_select_field_o = word_reg;
  assign byte_select_o = byte_reg;
  assign word_field_nonzero_o = nz_reg;
  assign concurrent_section_busy_o = busy_reg;
  assign fetch_blocked_o = blk_reg;
  assign cpu_stall_o = stall_o_reg;
endmodule // boot_section_address_map

//--- include/boot_map_pkg.sv
// Purpose: constants for the boot section address map and pointer split
// Assumes: word addressed flash, 64-word pages, 8K-word or 16K-word variant
// Notes: addresses are word addresses
package boot_map_pkg;
  localparam int PTR_W = 16;
  localparam int WORD_FIELD_W = 6;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = 7;
  localparam int PTR_PAGE_WORD_TOP = 6;
  localparam int CNT_TOP_8K = 12;
  localparam int CNT_TOP_16K = 13;
  localparam int PTR_CNT_TOP_8K = 13;
  localparam int PTR_CNT_TOP_16K = 14;
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 8;
  localparam logic [ADDR_W-1:0] FLASH_END_8K = 14'h1FFF;
  localparam logic [ADDR_W-1:0] FLASH_END_16K = 14'h3FFF;
  localparam logic [ADDR_W-1:0] BOOT_11_8K = 14'h1F00;
  localparam logic [ADDR_W-1:0] BOOT_10_8K = 14'h1E00;
  localparam logic [ADDR_W-1:0] BOOT_01_8K = 14'h1C00;
  localparam logic [ADDR_W-1:0] BOOT_00_8K = 14'h1800;
  localparam logic [ADDR_W-1:0] BOOT_11_16K = 14'h3F00;
  localparam logic [ADDR_W-1:0] BOOT_10_16K = 14'h3E00;
  localparam logic [ADDR_W-1:0] BOOT_01_16K = 14'h3C00;
  localparam logic [ADDR_W-1:0] BOOT_00_16K = 14'h3800;
  localparam logic [ADDR_W-1:0] STALL_START_8K = 14'h1800;
  localparam logic [ADDR_W-1:0] STALL_START_16K = 14'h3800;
  localparam logic [PAGE_W-1:0] BOOT_PAGES_11 = 8'h04;
  localparam logic [PAGE_W-1:0] BOOT_PAGES_10 = 8'h08;
  localparam logic [PAGE_W-1:0] BOOT_PAGES_01 = 8'h10;
  localparam logic [PAGE_W-1:0] BOOT_PAGES_00 = 8'h20;
  localparam logic [PAGE_W-1:0] STALL_PAGES = 8'h20;
  localparam logic [PAGE_W-1:0] CONC_PAGES_8K = 8'h60;
  localparam logic [PAGE_W-1:0] CONC_PAGES_16K = 8'hE0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONC = 3'b010,
    ST_STALL = 3'b100
  } prog_state_t;
endpackage

//--- testbench/boot_map_asserts.sv
// Purpose: port checks for the boot section map
// Assumes: variant and fuse steady between resets
// Notes: bound to the design top
`timescale 1ns/100ps
module boot_map_asserts
  import boot_map_pkg::*;
(
  input wire logic mclk_i, rst_i, large_variant_i, boot_size_sel_hi_i, boot_size_sel_lo_i, // clock, reset, config
  input wire logic prog_start_i, prog_is_write_i, prog_done_i, byte_select_o, // strobes
  input wire logic concurrent_section_busy_o, cpu_stall_o, // status
  input wire logic fetch_blocked_o, // blocked cpu read
  input wire logic [ADDR_W-1:0] fetch_addr_i, // cpu read address
  input wire logic [PTR_W-1:0] pointer_i, // z pointer
  input wire logic [ADDR_W-1:0] boot_start_o, app_end_o, stall_start_o, counter_top_bit_o, // map
  input wire logic [PAGE_W-1:0] boot_pages_o, conc_pages_o, page_select_field_o, // pages
  input wire logic [WORD_FIELD_W-1:0] word_select_field_o // word in page
);
  logic up_reg, up2_reg, op_reg, lv_reg, hit;
  logic [1:0] fz_reg;
  logic [PTR_W-1:0] ptr_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {up_reg, up2_reg, op_reg, lv_reg, fz_reg, ptr_reg} <= '0;
    end else begin
      {up_reg, lv_reg, fz_reg, ptr_reg} <= {1'b1, large_variant_i, boot_size_sel_hi_i, boot_size_sel_lo_i, pointer_i};
      up2_reg <= up_reg;
      op_reg <= !prog_done_i && (op_reg || prog_start_i);
    end
  end
  assign hit = large_variant_i ? &pointer_i[14:12] : &pointer_i[13:12];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // variant-dependent outputs follow the config two edges after reset
  a_boot_start: assert property (up2_reg |->
    boot_start_o == {lv_reg, 13'h1FFF} - (14'h0100 << ~fz_reg) + 14'h0001)
    else $error("boot start");
  a_app_end: assert property (up2_reg |->
    app_end_o == boot_start_o - 14'h0001 && boot_pages_o == (8'h04 << ~fz_reg))
    else $error("app end");
  a_stall_split: assert property (up2_reg |->
    stall_start_o == {lv_reg, 13'h1800} && conc_pages_o == (lv_reg ? 8'hE0 : 8'h60))
    else $error("split");
  a_counter_top: assert property (up2_reg |-> counter_top_bit_o == {lv_reg, !lv_reg, 12'h000})
    else $error("counter top");
  a_page_field: assert property (up2_reg |->
    page_select_field_o == (lv_reg ? ptr_reg[14:7] : {1'b0, ptr_reg[13:7]}))
    else $error("page field");
  a_word_field: assert property (up_reg |-> word_select_field_o == ptr_reg[6:1] && byte_select_o == ptr_reg[0])
    else $error("word field");
  a_stall_rise: assert property (up_reg && !op_reg && prog_start_i && prog_is_write_i && hit |=> cpu_stall_o)
    else $error("no stall");
  a_stall_hold: assert property (cpu_stall_o |=> cpu_stall_o != $past(prog_done_i))
    else $error("stall length");
  a_busy_rise: assert property (up_reg && !op_reg && prog_start_i && !hit |=>
    concurrent_section_busy_o && !cpu_stall_o)
    else $error("no busy");
  a_busy_hold: assert property (concurrent_section_busy_o && op_reg && !prog_done_i |=> concurrent_section_busy_o)
    else $error("busy dropped");
  a_fetch_block: assert property (up_reg |-> fetch_blocked_o ==
    (concurrent_section_busy_o && $past(fetch_addr_i) < stall_start_o))
    else $error("fetch block");
endmodule // boot_map_asserts
bind boot_section_address_map boot_map_asserts boot_map_asserts_inst (.*);

//--- testbench/flash_array_model.sv
// Purpose: flash array stand-in that completes page operations
// Assumes: starts while busy are ignored, as by the array
// Notes: latency is chosen per operation by the bench
`timescale 1ns/100ps
module flash_array_model (
  input wire logic mclk_i, // cpu clock
  input wire logic rst_i, // async reset
  input wire logic prog_start_i, // operation start
  input wire logic [3:0] lat_i, // cycles to completion
  output logic prog_done_o // one-cycle completion
);
  logic [4:0] cnt_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) cnt_reg <= 5'h00;
    else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    else if (prog_start_i) cnt_reg <= {1'b0, lat_i} + 5'h01;
  end
  assign prog_done_o = cnt_reg == 5'h01;
endmodule // flash_array_model

//--- testbench/boot_section_address_map_tb_top.sv
// Purpose: self-checking bench for the boot section map
// Assumes: variant and fuse change only under reset
// Notes: driver queues expected outputs, monitor checks after each edge
`timescale 1ns/100ps
module boot_section_address_map_tb_top;
  import boot_map_pkg::*;
  typedef struct packed {logic [13:0] bs; logic [7:0] pg; logic [5:0] wd; logic [3:0] fl;} note_t;
  logic mclk_i = 1'b0, rst_i = 1'b1, large_variant_i = 1'b0, boot_size_sel_hi_i = 1'b0, boot_size_sel_lo_i = 1'b0;
  logic prog_start_i = 1'b0, prog_is_write_i = 1'b0, page_load_i = 1'b0, section_reenable_i = 1'b0, prog_done_i;
  logic [PTR_W-1:0] pointer_i = 16'h0000;
  logic [ADDR_W-1:0] fetch_addr_i = 14'h0000, boot_start_o, app_end_o, stall_start_o, counter_top_bit_o;
  logic [PAGE_W-1:0] boot_pages_o, conc_pages_o, page_select_field_o;
  logic [WORD_FIELD_W-1:0] word_select_field_o;
  logic byte_select_o, word_field_nonzero_o, concurrent_section_busy_o, fetch_blocked_o, cpu_stall_o;
  logic op_e = 1'b0, busy_e = 1'b0, stall_e = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [31:0] rng = 32'h00000009;
  int num_errors = 0, compares = 0, cycles = 0;
  note_t q[$];
  note_t got;
  boot_section_address_map boot_section_address_map_inst (.*);
  flash_array_model flash_array_model_inst (.mclk_i, .rst_i, .prog_start_i, .lat_i(lat), .prog_done_o(prog_done_i));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(logic s, logic w, logic l, logic r, logic [15:0] p);
    logic hit, nz;
    @(negedge mclk_i);
    {prog_start_i, prog_is_write_i, page_load_i, section_reenable_i, pointer_i} = {s, w, l, r, p};
    fetch_addr_i = 14'(rnd());
    hit = large_variant_i ? &p[14:12] : &p[13:12];
    nz = s & w & (p[6:1] != 6'h00);
    if (prog_done_i) {op_e, stall_e} = 2'b00;
    else if (s && !op_e) {op_e, busy_e, stall_e} = {1'b1, busy_e | !hit, w & hit};
    else if (!op_e && (l || r)) busy_e = 1'b0;
    q.push_back({{large_variant_i, 13'h1FFF} - (14'h0100 << ~{boot_size_sel_hi_i, boot_size_sel_lo_i}) + 14'h0001,
      large_variant_i ? p[14:7] : {1'b0, p[13:7]}, p[6:1], p[0], nz, busy_e, stall_e});
  endtask
  // start, a refused start and clear mid-operation, wait for done, then clear
  task automatic run_op(logic w, logic [15:0] p, logic clr);
    cyc(1'b1, w, 1'b0, 1'b0, p);
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 16'(rnd()));
    while (op_e) cyc(1'b0, 1'b0, 1'b0, 1'b0, 16'(rnd()));
    cyc(1'b0, 1'b0, clr, !clr, 16'(rnd()));
    cyc(1'b0, 1'b0, 1'b0, 1'b0, 16'(rnd()));
  endtask
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  always @(posedge mclk_i) begin
    #1;
    if (q.size() > 0) begin
      got = {boot_start_o, page_select_field_o, word_select_field_o, byte_select_o, word_field_nonzero_o,
        concurrent_section_busy_o, cpu_stall_o};
      compares++;
      if (got !== q[0]) begin
        num_errors++;
        $display("[ERR] outputs expected %h seen %h", q[0], got);
      end
      void'(q.pop_front());
    end
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      @(negedge mclk_i);
      rst_i = 1'b1;
      {large_variant_i, boot_size_sel_hi_i, boot_size_sel_lo_i} = 3'(c);
      {op_e, busy_e, stall_e} = 3'b000;
      repeat (5) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      for (int k = 0; k < 8; k++) begin
        lat = 4'(rnd()) | 4'h1;
        run_op(k[0], (16'(rnd()) & (k[2] ? 16'hEF80 : 16'hEFFF)) | (k[1] ? 16'h7000 : 16'h0000), k[2]);
      end
    end
    @(negedge mclk_i);
    finish_test();
  end
endmodule // boot_section_address_map_tb_top
